/* hrx_rx_ctrl.sv */
// module: hdlc receive control with dma hand-off, interrupt modes and end-of-frame lock
`default_nettype none
module hrx_rx_ctrl
	import hrx_pkg::*;
#(
	parameter int RXD = RX_DEPTH_DEF,
	parameter int FSD = FS_DEPTH_DEF
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              rx_bit_clock,
	input  wire logic              rxd,
	input  wire logic              dma_ack,
	output logic                   dma_req,
	output logic      [7:0]        dma_data,
	output logic                   irq,
	output logic                   sync_match_n
);
	localparam int LW  = $clog2(RXD + 1);
	localparam int FIW = $clog2(FSD);
	localparam int FCW = $clog2(FSD + 1);
	localparam logic [LW-1:0]  LVL_FULL = LW'(RXD);
	localparam logic [FCW-1:0] FS_FULL  = FCW'(FSD);
	localparam logic [FIW-1:0] FS_LAST  = FIW'(FSD - 1);

	typedef hrx_entry_t [RXD-1:0] hrx_rbuf_t;

	typedef struct packed {
		logic [2:0]           clk_sh;
		logic [1:0]           rxd_sh;
		logic [CTRL_W-1:0]    ctrl;
		hrx_rx_st_t           rx_st;
		logic [2:0]           ones;
		logic [7:0]           shreg;
		logic [2:0]           bitcnt;
		logic [13:0]          fbytes;
		logic [15:0]          crc;
		logic                 frame_ovr;
		logic                 dly_act;
		logic [1:0]           dly_cnt;
		logic [7:0]           pend;
		logic                 sync_wait;
		hrx_rbuf_t            rbuf;
		logic [LW-1:0]        lvl;
		hrx_fs_t [FSD-1:0]    fs;
		logic [FIW-1:0]       fs_wr;
		logic [FIW-1:0]       fs_rd;
		logic [FCW-1:0]       fs_cnt;
		logic                 locked;
		logic                 eof_st;
		logic                 crc_err;
		logic                 ovr_st;
		logic                 abort_st;
		logic                 ext_p;
		logic                 rxc_p;
		logic                 spec_p;
		logic                 first_arm;
		logic [31:0]          prdata;
		logic                 pready;
		logic                 pslverr;
		logic                 dma_req;
		logic [7:0]           dma_data;
		logic                 irq;
		logic                 sync_n;
	} hrx_state_t;

	function automatic hrx_rbuf_t pop_buf(input hrx_rbuf_t b);
		hrx_rbuf_t r;
		r = '0;
		for (int i = 0; i < RXD - 1; i++) begin
			r[i] = b[i+1];
		end
		return r;
	endfunction

	function automatic logic [FIW-1:0] inc_idx(input logic [FIW-1:0] i);
		return (i == FS_LAST) ? '0 : i + 1'b1;
	endfunction

	hrx_state_t st_q;
	hrx_state_t st_d;

	logic       bit_ev;
	logic       rx_bit;
	logic       flag_ev;
	logic       abort_ev;
	logic       dbit_ev;
	logic       apb_setup;
	logic       apb_acc;
	logic       dma_rd;
	logic       data_rd;
	logic [1:0] mode;

	// only the second and third sync stages are looked at
	assign bit_ev    = st_q.clk_sh[1] & ~st_q.clk_sh[2] & st_q.ctrl[CTRL_RXEN];
	assign rx_bit    = st_q.rxd_sh[1];
	assign flag_ev   = bit_ev & ~rx_bit & (st_q.ones == FLAG_RUN);
	assign abort_ev  = bit_ev & rx_bit & (st_q.ones == FLAG_RUN);
	assign dbit_ev   = bit_ev & (st_q.rx_st == HRX_SYNC) &
		(rx_bit ? (st_q.ones < STUFF_RUN) : (st_q.ones < STUFF_RUN));
	assign apb_setup = psel & ~penable;
	assign apb_acc   = psel & penable & st_q.pready;
	assign dma_rd    = dma_ack & st_q.dma_req;
	assign data_rd   = apb_acc & ~pwrite & (paddr == ADDR_DATA);
	assign mode      = st_q.ctrl[CTRL_MODE +: 2];

	always_comb begin
		logic [31:0] sw;
		hrx_fs_t     fe;
		sw = '0;
		fe = '0;
		st_d = st_q;
		st_d.clk_sh = {st_q.clk_sh[1:0], rx_bit_clock};
		st_d.rxd_sh = {st_q.rxd_sh[0], rxd};

		// register bus: zero-wait, answer prepared in the setup cycle
		st_d.pready  = apb_setup;
		st_d.pslverr = 1'b0;
		if (apb_setup) begin
			sw[STAT_HUNT]  = (st_q.rx_st == HRX_HUNT);
			sw[STAT_LOCK]  = st_q.locked;
			sw[STAT_EOF]   = st_q.eof_st;
			sw[STAT_CRC]   = st_q.crc_err;
			sw[STAT_OVR]   = st_q.ovr_st;
			sw[STAT_ABORT] = st_q.abort_st;
			sw[STAT_EXT]   = st_q.ext_p;
			sw[STAT_RXC]   = st_q.rxc_p;
			sw[STAT_SPEC]  = st_q.spec_p;
			sw[STAT_LVL +: LW] = st_q.lvl;
			case (paddr)
				ADDR_CTRL:  st_d.prdata = 32'(st_q.ctrl);
				ADDR_CMD:   st_d.prdata = '0;
				ADDR_STAT:  st_d.prdata = sw;
				ADDR_DATA:  st_d.prdata = 32'(st_q.rbuf[0].data);
				ADDR_FSTAT: st_d.prdata = 32'({st_q.fs_cnt != '0, st_q.fs[st_q.fs_rd]});
				default: begin
					st_d.prdata  = '0;
					st_d.pslverr = 1'b1;
				end
			endcase
		end

		// software writes and commands; hardware sets further down win
		if (apb_acc && pwrite && paddr == ADDR_CTRL) begin
			st_d.ctrl = pwdata[CTRL_W-1:0];
		end
		if (apb_acc && pwrite && paddr == ADDR_CMD) begin
			if (pwdata[CMD_ERR_RST]) begin
				st_d.locked  = 1'b0;
				st_d.spec_p  = 1'b0;
				st_d.eof_st  = 1'b0;
				st_d.ovr_st  = 1'b0;
				st_d.crc_err = 1'b0;
				// kept check byte is re-offered to dma, or dropped when dma is off
				if (st_q.locked && !st_q.ctrl[CTRL_DMAEN] && st_d.lvl != '0) begin
					st_d.rbuf = pop_buf(st_d.rbuf);
					st_d.lvl  = st_d.lvl - 1'b1;
				end
			end
			if (pwdata[CMD_EN_NEXT]) begin
				st_d.first_arm = 1'b1;
			end
			if (pwdata[CMD_RST_EXT]) begin
				st_d.ext_p    = 1'b0;
				st_d.abort_st = 1'b0;
			end
		end

		// buffer reads by dma or software
		if ((dma_rd || data_rd) && st_d.lvl != '0) begin
			if (st_d.rbuf[0].eof) begin
				// byte stays at the top so it can be offered again after unlock
				st_d.rbuf[0].eof = 1'b0;
				st_d.locked      = 1'b1;
				st_d.spec_p      = 1'b1;
				st_d.eof_st      = 1'b1;
			end else begin
				if (st_d.rbuf[0].ovr) begin
					st_d.spec_p = 1'b1;
				end
				st_d.rbuf = pop_buf(st_d.rbuf);
				st_d.lvl  = st_d.lvl - 1'b1;
				if (st_d.lvl == '0) begin
					st_d.rxc_p = 1'b0;
				end
			end
		end
		if (apb_acc && !pwrite && paddr == ADDR_FSTAT && st_q.fs_cnt != '0) begin
			st_d.fs_rd  = inc_idx(st_q.fs_rd);
			st_d.fs_cnt = st_d.fs_cnt - 1'b1;
		end

		// receive line, one step per sampled bit
		if (bit_ev) begin
			st_d.sync_n    = ~st_q.sync_wait;
			st_d.sync_wait = flag_ev;
			st_d.ones      = rx_bit ? ((st_q.ones == ABORT_RUN) ? ABORT_RUN : st_q.ones + 1'b1)
				: '0;
			if (st_q.dly_act) begin
				st_d.dly_cnt = st_q.dly_cnt - 1'b1;
				if (st_q.dly_cnt == 2'h1) begin
					st_d.dly_act = 1'b0;
					// a full buffer marks the newest byte instead of losing order
					if (st_d.lvl == LVL_FULL) begin
						st_d.rbuf[st_d.lvl - 1'b1].ovr = 1'b1;
						st_d.ovr_st    = 1'b1;
						st_d.frame_ovr = 1'b1;
					end else begin
						st_d.rbuf[st_d.lvl] = '{data: st_q.pend, eof: 1'b0, ovr: 1'b0};
						st_d.lvl = st_d.lvl + 1'b1;
						if (mode == MODE_ALL) begin
							st_d.rxc_p = 1'b1;
						end else if (mode == MODE_FIRST && st_d.first_arm) begin
							st_d.rxc_p     = 1'b1;
							st_d.first_arm = 1'b0;
						end
					end
				end
			end
		end
		case (st_q.rx_st)
			HRX_HUNT: begin
				if (flag_ev) begin
					st_d.rx_st     = HRX_SYNC;
					st_d.ext_p     = 1'b1;
					st_d.first_arm = 1'b1;
					st_d.bitcnt    = '0;
					st_d.fbytes    = '0;
					st_d.crc       = CRC_INIT;
					st_d.frame_ovr = 1'b0;
				end
			end
			HRX_SYNC: begin
				if (abort_ev || !st_q.ctrl[CTRL_RXEN]) begin
					st_d.rx_st    = HRX_HUNT;
					st_d.ext_p    = st_d.ext_p | abort_ev;
					st_d.abort_st = st_d.abort_st | abort_ev;
					st_d.dly_act  = 1'b0;
				end else if (flag_ev) begin
					// closing flag may also open the next frame, so stay in sync
					st_d.bitcnt    = '0;
					st_d.fbytes    = '0;
					st_d.crc       = CRC_INIT;
					st_d.frame_ovr = 1'b0;
					if (st_q.fbytes != '0) begin
						st_d.crc_err   = (st_q.crc != CRC_GOOD);
						st_d.first_arm = 1'b0;
						if (st_d.lvl != '0) begin
							st_d.rbuf[st_d.lvl - 1'b1].eof = 1'b1;
						end else begin
							st_d.locked = 1'b1;
							st_d.spec_p = 1'b1;
							st_d.eof_st = 1'b1;
						end
						if (mode == MODE_SPEC && st_d.fs_cnt != FS_FULL) begin
							fe.cnt = st_q.fbytes;
							fe.ovr = st_q.frame_ovr;
							fe.crc = (st_q.crc != CRC_GOOD);
							fe.par = 1'b0;
							st_d.fs[st_q.fs_wr] = fe;
							st_d.fs_wr  = inc_idx(st_q.fs_wr);
							st_d.fs_cnt = st_d.fs_cnt + 1'b1;
						end
					end
				end else if (dbit_ev) begin
					st_d.shreg  = {rx_bit, st_q.shreg[7:1]};
					st_d.bitcnt = st_q.bitcnt + 1'b1;
					if (st_q.bitcnt == LAST_BIT) begin
						st_d.dly_act = 1'b1;
						st_d.dly_cnt = CHAR_DELAY;
						st_d.pend    = st_d.shreg;
						st_d.crc     = crc_byte(st_q.crc, st_d.shreg);
						if (st_q.fbytes != CNT_MAX) begin
							st_d.fbytes = st_q.fbytes + 1'b1;
						end
					end
				end
			end
			default: st_d.rx_st = HRX_HUNT;
		endcase
		if (abort_ev && st_q.ctrl[CTRL_ABIE]) begin
			st_d.ext_p    = 1'b1;
			st_d.abort_st = 1'b1;
		end

		// registered outputs
		st_d.dma_req  = st_d.ctrl[CTRL_DMAEN] & st_d.ctrl[CTRL_MODE] & ~st_d.locked
			& (st_d.lvl != '0);
		st_d.dma_data = st_d.rbuf[0].data;
		st_d.irq      = st_d.ext_p | st_d.rxc_p | st_d.spec_p;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q        <= '0;
			st_q.ctrl   <= CTRL_RST;
			st_q.rx_st  <= HRX_HUNT;
			st_q.crc    <= CRC_INIT;
			st_q.sync_n <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata       = st_q.prdata;
	assign pready       = st_q.pready;
	assign pslverr      = st_q.pslverr;
	assign dma_req      = st_q.dma_req;
	assign dma_data     = st_q.dma_data;
	assign irq          = st_q.irq;
	assign sync_match_n = st_q.sync_n;

	// helper: bit-times since the last character completed
	logic [3:0] a_bits;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_bits <= '0;
		end else if (dbit_ev && st_q.bitcnt == LAST_BIT && !flag_ev && !abort_ev) begin
			a_bits <= '0;
		end else if (bit_ev && a_bits != 4'hf) begin
			a_bits <= a_bits + 1'b1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_first_irq: assert property ($rose(st_q.rxc_p) && mode == MODE_FIRST |->
		a_bits == 4'(CHAR_DELAY)) else $error("first char irq late");
	chk_spec_norxc: assert property ($rose(st_q.rxc_p) |->
		$past(mode) != MODE_SPEC) else $error("char irq in special mode");
	chk_hunt_exit: assert property (flag_ev && st_q.rx_st == HRX_HUNT |=>
		st_q.rx_st == HRX_SYNC && st_q.ext_p && irq) else $error("no sync entry");
	chk_sync_pulse: assert property ($fell(sync_match_n) |->
		$past(bit_ev) && $past(st_q.sync_wait)) else $error("sync pulse misplaced");
	chk_eof_lock: assert property ((dma_rd && st_q.lvl != '0 && st_q.rbuf[0].eof) |=>
		st_q.locked && irq && !dma_req) else $error("eof did not lock");
	chk_lock_noreq: assert property (st_q.locked |-> !dma_req)
		else $error("request while locked");
	chk_err_unlock: assert property (apb_acc && pwrite && paddr == ADDR_CMD
		&& pwdata[CMD_ERR_RST] |=> !st_q.locked) else $error("still locked");
	chk_ovr_spec: assert property ((dma_rd && st_q.lvl != '0 && st_q.rbuf[0].ovr
		&& !st_q.rbuf[0].eof) |=> st_q.spec_p ##0 irq) else $error("overrun lost");
	chk_abort_hunt: assert property (abort_ev && st_q.rx_st == HRX_SYNC |=>
		st_q.rx_st == HRX_HUNT && st_q.ext_p) else $error("abort not handled");
	chk_req_drop: assert property ((dma_rd && st_q.lvl == 1 && !st_q.rbuf[0].eof
		&& !bit_ev) |=> !dma_req) else $error("request did not drop");
	chk_rearm_req: assert property (apb_acc && pwrite && paddr == ADDR_CMD
		&& pwdata[CMD_ERR_RST] && st_q.locked && st_q.ctrl[CTRL_DMAEN]
		&& st_q.ctrl[CTRL_MODE] && st_q.lvl != '0 |=> dma_req)
		else $error("check byte not re-requested");
endmodule
`default_nettype wire

/* hrx_pkg.sv */
// package: constants, register map and record types for the hdlc receive control block
`default_nettype none
package hrx_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CMD   = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_STAT  = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_DATA  = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_FSTAT = 8'h10;
	// rx_irq_config_reg layout
	localparam int CTRL_W      = 5;
	localparam int CTRL_RXEN   = 0;
	localparam int CTRL_DMAEN  = 1;
	localparam int CTRL_ABIE   = 2;
	localparam int CTRL_MODE   = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [1:0] MODE_OFF   = 2'h0;
	localparam logic [1:0] MODE_ALL   = 2'h2;
	localparam logic [1:0] MODE_FIRST = 2'h1;
	localparam logic [1:0] MODE_SPEC  = 2'h3;
	// command register bits, write-one pulses
	localparam int CMD_ERR_RST = 0;
	localparam int CMD_EN_NEXT = 1;
	localparam int CMD_RST_EXT = 2;
	// status register bits, and the valid bit of the frame status register
	localparam int STAT_HUNT  = 0;
	localparam int STAT_LOCK  = 1;
	localparam int STAT_EOF   = 2;
	localparam int STAT_CRC   = 3;
	localparam int STAT_OVR   = 4;
	localparam int STAT_ABORT = 5;
	localparam int STAT_EXT   = 6;
	localparam int STAT_RXC   = 7;
	localparam int STAT_SPEC  = 8;
	localparam int STAT_LVL   = 9;
	localparam int FS_VALID   = 17;
	// line coding
	localparam logic [2:0] STUFF_RUN = 3'h5;
	localparam logic [2:0] FLAG_RUN  = 3'h6;
	localparam logic [2:0] ABORT_RUN = 3'h7;
	localparam logic [2:0] LAST_BIT  = 3'h7;
	localparam int BYTE_BITS     = 8;
	localparam int IRQ_LAT_BITS  = 11;
	localparam logic [1:0] CHAR_DELAY = 2'(IRQ_LAT_BITS - BYTE_BITS);
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_GOOD = 16'hf0b8;
	localparam logic [13:0] CNT_MAX  = 14'h3fff;
	localparam int RX_DEPTH_DEF = 3;
	localparam int FS_DEPTH_DEF = 10;

	typedef enum logic [1:0] {HRX_HUNT = 2'b01, HRX_SYNC = 2'b10} hrx_rx_st_t;

	typedef struct packed {
		logic [7:0] data;
		logic       eof;
		logic       ovr;
	} hrx_entry_t;

	typedef struct packed {
		logic        crc;
		logic        par;
		logic        ovr;
		logic [13:0] cnt;
	} hrx_fs_t;

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] v);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < BYTE_BITS; i++) begin
			r = (r[0] ^ v[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
endpackage
`default_nettype wire

/* hrx_line_model.sv */
// line model: serial frame source driving the receive bit clock and data pin
`default_nettype none
module hrx_line_model (
	output logic rx_bit_clock,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 100ps;
	realtime    t_bit;
	realtime    t_byte;
	realtime    t_flag;
	int         ones;
	logic [7:0] sent[$];
	// clock stands still between frames; a marking line idles high
	initial begin
		rx_bit_clock = 1'b0;
		rxd          = 1'b1;
		ones         = 0;
	end
	// data moves while the clock is low, so each rising edge sees a settled level
	task automatic bit_out(input logic b);
		rxd = b;
		#200;
		rx_bit_clock = 1'b1;
		t_bit = $realtime;
		#200;
		rx_bit_clock = 1'b0;
	endtask
	task automatic flag();
		for (int i = 0; i < 8; i++) bit_out(i != 0 && i != 7);
		ones = 0;
		t_flag = t_bit;
	endtask
	task automatic abort_run();
		repeat (8) bit_out(1'b1);
	endtask
	// lsb first with a zero after five ones, so data never looks like a flag
	task automatic data_byte(input logic [7:0] v);
		sent.push_back(v);
		for (int i = 0; i < 8; i++) begin
			bit_out(v[i]);
			ones = v[i] ? ones + 1 : 0;
			if (i == 7) t_byte = t_bit;
			if (ones == 5) begin
				bit_out(1'b0);
				ones = 0;
			end
		end
	endtask
	// check bytes are the inverted crc, low byte first
	task automatic frame(input logic [7:0] d[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (d[k]) begin
			data_byte(d[k]);
			for (int i = 0; i < 8; i++) c = (c[0] ^ d[k][i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
		end
		data_byte(~c[7:0]);
		data_byte(~c[15:8]);
	endtask
endmodule
`default_nettype wire

/* tb_hdlc_rx_dma_irq_control.sv */
// testbench: register table, first-character and special-only reception, abort
`default_nettype none
module tb_hdlc_rx_dma_irq_control import hrx_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [31:0] wd;
		logic [31:0] ex;
		logic        er;
	} hrx_tb_row_t;
	logic              pclk = 1'b0;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              rx_bit_clock;
	logic              rxd;
	logic              dma_ack;
	logic              dma_req;
	logic [7:0]        dma_data;
	logic              irq;
	logic              sync_match_n;
	logic              ack_en;
	logic [7:0]        got[$];
	logic [31:0]       rd;
	logic [31:0]       fs;
	logic              er;
	int                checks = 0;
	int                failures = 0;
	int                low_cnt = 0;
	int                sync_w = 0;
	realtime           d;
	hrx_tb_row_t       rows [10] = '{
		'{1'b0, ADDR_CTRL, 32'h0, 32'h0, 1'b0},
		'{1'b0, ADDR_STAT, 32'h0, 32'h1, 1'b0},
		'{1'b1, ADDR_CTRL, 32'hffffffff, 32'h0, 1'b0},
		'{1'b0, ADDR_CTRL, 32'h0, 32'h1f, 1'b0},
		'{1'b1, ADDR_CTRL, 32'h11, 32'h0, 1'b0},
		'{1'b0, ADDR_CTRL, 32'h0, 32'h11, 1'b0},
		'{1'b0, ADDR_CMD, 32'h0, 32'h0, 1'b0},
		'{1'b1, 8'h14, 32'h5, 32'h0, 1'b1},
		'{1'b0, 8'h14, 32'h0, 32'h0, 1'b1},
		'{1'b0, ADDR_FSTAT, 32'h0, 32'h0, 1'b0}
	};
	hrx_rx_ctrl u_hrx_rx_ctrl (
		.pclk         (pclk),
		.presetn      (presetn),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr),
		.rx_bit_clock (rx_bit_clock),
		.rxd          (rxd),
		.dma_ack      (dma_ack),
		.dma_req      (dma_req),
		.dma_data     (dma_data),
		.irq          (irq),
		.sync_match_n (sync_match_n)
	);
	hrx_line_model u_hrx_line_model (
		.rx_bit_clock (rx_bit_clock),
		.rxd          (rxd)
	);
	always #25 pclk = ~pclk;
	// width of the latest sync pulse in clock cycles
	always @(posedge pclk) begin
		if (sync_match_n === 1'b0) begin
			low_cnt <= low_cnt + 1;
		end else if (low_cnt != 0) begin
			sync_w  <= low_cnt;
			low_cnt <= 0;
		end
	end
	// dma side: one read per request, recorded at the accepting edge
	always @(posedge pclk) begin
		dma_ack <= ack_en && dma_req === 1'b1 && !dma_ack;
		if (dma_req === 1'b1 && dma_ack === 1'b1) got.push_back(dma_data);
	end
	task automatic close_out();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		checks++;
		if (seen !== ex) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic wait_for(ref logic s, input logic lv, input int n);
		int k;
		k = 0;
		while (s !== lv && k < n) begin
			@(posedge pclk);
			k++;
		end
		if (k >= n) begin
			failures++;
			close_out();
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			failures++;
			close_out();
		end
	endtask
	// a hang anywhere ends the run as a failure
	initial begin
		#4000000;
		failures++;
		close_out();
	end
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = '0;
		pwdata  = '0;
		dma_ack = 1'b0;
		ack_en  = 1'b0;
		repeat (16) @(posedge pclk);
		chk("irq in reset", irq, 0);
		chk("request in reset", dma_req, 0);
		chk("sync in reset", sync_match_n, 1);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].wd, rd, er);
			if (!rows[i].w) chk("read data", rd, rows[i].ex);
			chk("slave error", er, rows[i].er);
		end
		// first-character mode with dma held off until the host sees the interrupt
		apb(1'b1, ADDR_CTRL, 32'h0b, rd, er);
		fork
			begin
				u_hrx_line_model.flag();
				u_hrx_line_model.frame('{8'h81, 8'h42, 8'hff, 8'h42});
				u_hrx_line_model.flag();
			end
			begin
				wait_for(sync_match_n, 1'b0, 400);
				d = $realtime - u_hrx_line_model.t_flag;
				chk("sync delay", d >= 400.0 && d <= 650.0, 1);
				wait_for(irq, 1'b1, 40);
				apb(1'b0, ADDR_STAT, 32'h0, rd, er);
				chk("hunt exit", rd & 32'h41, 32'h40);
				apb(1'b1, ADDR_CMD, 32'h4, rd, er);
				wait_for(irq, 1'b0, 10);
				wait_for(irq, 1'b1, 300);
				d = $realtime - u_hrx_line_model.t_byte;
				chk("first char delay", d >= 1200.0 && d <= 1600.0, 1);
				apb(1'b0, ADDR_STAT, 32'h0, rd, er);
				chk("first char pending", rd[STAT_RXC], 1);
				ack_en <= 1'b1;
				wait_for(irq, 1'b0, 100);
				// a slow dma side leaves the last check byte unread until the closing flag
				for (int k = 0; k < 2000 && got.size() < 5; k++) @(posedge pclk);
				ack_en <= 1'b0;
				chk("bytes before hold", 32'(got.size()), 5);
				repeat (200) @(posedge pclk);
				chk("eof held off", irq, 0);
				chk("check byte offered", dma_req, 1);
				ack_en <= 1'b1;
				wait_for(irq, 1'b1, 1000);
				chk("bytes before eof", 32'(got.size()), 6);
				foreach (got[i]) chk("dma byte", got[i], u_hrx_line_model.sent[i]);
				apb(1'b0, ADDR_STAT, 32'h0, rd, er);
				chk("lock and eof", rd & 32'he, 32'h6);
				repeat (20) @(posedge pclk);
				chk("request while locked", dma_req, 0);
				ack_en <= 1'b0;
				apb(1'b1, ADDR_CMD, 32'h1, rd, er);
				wait_for(dma_req, 1'b1, 20);
				chk("check byte again", dma_data, u_hrx_line_model.sent[5]);
				apb(1'b1, ADDR_CTRL, 32'h09, rd, er);
				// with dma off, software takes the kept byte itself
				apb(1'b0, ADDR_DATA, 32'h0, rd, er);
				chk("kept byte by software", rd, 32'(u_hrx_line_model.sent[5]));
				apb(1'b1, ADDR_CMD, 32'h1, rd, er);
				apb(1'b0, ADDR_STAT, 32'h0, rd, er);
				chk("clean after reset", rd & 32'h606, 0);
				chk("sync width", sync_w, 8);
			end
		join
		// special-only mode, back-to-back frames sharing one flag
		apb(1'b1, ADDR_CTRL, 32'h1b, rd, er);
		got.delete();
		u_hrx_line_model.sent.delete();
		ack_en <= 1'b1;
		fork
			begin
				u_hrx_line_model.flag();
				u_hrx_line_model.frame('{8'h01, 8'h03});
				u_hrx_line_model.flag();
				u_hrx_line_model.frame('{8'hc0, 8'hde, 8'h55});
				u_hrx_line_model.flag();
			end
			begin
				wait_for(irq, 1'b1, 1500);
				chk("no char irq", 32'(got.size()), 4);
				// hold the lock for 32 bit-times while the next frame arrives
				repeat (256) @(posedge pclk);
				apb(1'b0, ADDR_STAT, 32'h0, rd, er);
				chk("no overrun while locked", rd[STAT_OVR], 0);
				apb(1'b1, ADDR_CMD, 32'h1, rd, er);
				wait_for(irq, 1'b0, 20);
				wait_for(irq, 1'b1, 1500);
				chk("bytes of both frames", 32'(got.size()), 9);
				foreach (got[i]) chk("dma byte", got[i], u_hrx_line_model.sent[i]);
				apb(1'b1, ADDR_CMD, 32'h1, rd, er);
			end
		join
		fs = '0;
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, ADDR_FSTAT, 32'h0, rd, er);
			if (rd[FS_VALID]) fs = rd;
		end
		chk("frame status", fs, 32'h20005);
		// abort on a marking line drops back to hunt
		apb(1'b1, ADDR_CMD, 32'h4, rd, er);
		u_hrx_line_model.flag();
		u_hrx_line_model.abort_run();
		wait_for(irq, 1'b1, 100);
		apb(1'b0, ADDR_STAT, 32'h0, rd, er);
		chk("abort to hunt", rd & 32'h41, 32'h41);
		close_out();
	end
endmodule
`default_nettype wire
